// ===== common/slic_pkg.sv
// package: register map, field layout and timing of the status led logic
`default_nettype none
package slic_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_BEHAVIOUR = 16'h40c0;
  localparam logic [15:0] IDX_COMMON    = 16'h40c1;
  localparam logic [15:0] IDX_BLINK     = 16'h40c2;
  localparam logic [15:0] IDX_STATUS    = 16'h40cf;
  // reset values
  localparam logic [15:0] RST_BEHAVIOUR = 16'h0311;
  localparam logic [15:0] RST_COMMON    = 16'h00cc;
  localparam logic [15:0] RST_BLINK     = 16'hec75;
  localparam logic [15:0] COMMON_MASK   = 16'h03ff; // 15:10 reserved
  // behaviour register fields
  localparam int B_FORCE_EN = 15;
  localparam int B_FSEL_HI  = 14;
  localparam int B_FSEL_LO  = 13;
  localparam int B_ACT_ALW  = 12;
  localparam int B_FDX_ON   = 11;
  localparam int B_HDX_ON   = 10;
  localparam int B_TX_BLK   = 9;
  localparam int B_RX_BLK   = 8;
  localparam int B_TX_ON    = 7;
  localparam int B_RX_ON    = 6;
  localparam int B_FAST_ON  = 5;
  localparam int B_SLOW_ON  = 4;
  localparam int B_COL_BLK  = 3;
  localparam int B_FAST_BLK = 2;
  localparam int B_SLOW_BLK = 1;
  localparam int B_CHECK    = 0;
  // common register fields
  localparam int C_INVERT   = 9;
  localparam int C_LPBK_SUP = 8;
  localparam int C_JAB_SUP  = 7;
  localparam int C_COL_SEL  = 6;
  localparam int C_LVL_EN   = 5;
  localparam int C_TH_HI    = 4;
  localparam int FREQ_W     = 4;
  // force selection codes
  localparam logic [1:0] FORCE_OFF   = 2'h0;
  localparam logic [1:0] FORCE_ON    = 2'h1;
  localparam logic [1:0] FORCE_BLK1  = 2'h2;
  localparam logic [1:0] FORCE_BLK2  = 2'h3;
  // timing
  localparam int CLK_NS       = 10;
  localparam int MS_NS        = 1000000;
  localparam int ACT_HOLD_MS  = 10;
  localparam int WINDOW_MS    = 1000;
  localparam int TH_UNIT_MS   = 42;
  localparam int MS_W         = 14;
  localparam int MS_CYCLES    = MS_NS / CLK_NS;
  // what drives the led this cycle
  typedef enum logic [5:0] {
    SLIC_SRC_OFF   = 6'h01,
    SLIC_SRC_ON    = 6'h02,
    SLIC_SRC_BLK0  = 6'h04,
    SLIC_SRC_BLK1  = 6'h08,
    SLIC_SRC_BLK2  = 6'h10,
    SLIC_SRC_BLK3  = 6'h20
  } slic_src_t;
  // state reported by the phy core
  typedef struct packed {
    logic link_up;
    logic speed_fast;   // 1 = 100 Mbps, 0 = 10 Mbps
    logic full_duplex;
    logic collision;
    logic jabber;
    logic loopback;
    logic phy_active;
    logic an_link_check;
    logic tx_active;
    logic rx_active;
  } slic_phy_status_t;
endpackage
`default_nettype wire

// ===== logic/slic_top.sv
// status led indication logic with its ahb-lite register slave
//
// Design decision made here: register access over AHB-Lite.
`default_nettype none
module slic_top #(
  parameter int MS_TICKS = slic_pkg::MS_CYCLES
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire slic_pkg::slic_phy_status_t  phy_status,
  output logic                             led_out
);

  // ----------------------------------------------------------------
  // blink frequency table
  // ----------------------------------------------------------------
  // period and off time in ms for each frequency code
  function automatic logic [27:0] freq_entry(input logic [3:0] code);
    logic [27:0] e;
    e = 28'h0;
    unique case (code)
      4'h0: e = {14'd10000, 14'd600};
      4'h1: e = {14'd9400, 14'd658};
      4'h2: e = {14'd8000, 14'd640};
      4'h3: e = {14'd7400, 14'd666};
      4'h4: e = {14'd6000, 14'd660};
      4'h5: e = {14'd4000, 14'd320};
      4'h6: e = {14'd4000, 14'd320};
      4'h7: e = {14'd3000, 14'd330};
      4'h8: e = {14'd2000, 14'd320};
      4'h9: e = {14'd1000, 14'd160};
      4'ha: e = {14'd500, 14'd250};
      4'hb: e = {14'd333, 14'd167};
      4'hc: e = {14'd250, 14'd125};
      4'hd: e = {14'd167, 14'd83};
      4'he: e = {14'd125, 14'd62};
      4'hf: e = {14'd125, 14'd62};
    endcase
    return e;
  endfunction

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  logic [15:0] behaviour_reg;
  logic [15:0] behaviour_next;
  logic [15:0] common_reg;
  logic [15:0] common_next;
  logic [15:0] blink_reg;
  logic [15:0] blink_next;
  logic        wr_pend_reg;
  logic [15:0] wr_idx_reg;
  logic [31:0] hrdata_reg;

  // address phase decode
  wire         addr_take = hsel & htrans[1] & hready;
  wire  [15:0] addr_idx  = haddr[17:2];
  wire         rd_take   = addr_take & ~hwrite;
  wire         wr_take   = addr_take & hwrite;

  // data phase write decode
  wire         wr_beh    = wr_pend_reg &
                           (wr_idx_reg == slic_pkg::IDX_BEHAVIOUR);
  wire         wr_com    = wr_pend_reg & (wr_idx_reg == slic_pkg::IDX_COMMON);
  wire         wr_blk    = wr_pend_reg & (wr_idx_reg == slic_pkg::IDX_BLINK);

  assign behaviour_next = wr_beh ? hwdata[15:0] : behaviour_reg;
  assign common_next    = wr_com ? (hwdata[15:0] & slic_pkg::COMMON_MASK)
                                 : common_reg;
  assign blink_next     = wr_blk ? hwdata[15:0] : blink_reg;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // status word read by software
  logic        tx_heavy_reg;
  logic        rx_heavy_reg;
  logic        blink_active;
  logic [3:0]  phase_on;
  wire  [15:0] status_word = {8'h00, phase_on, blink_active,
                              tx_heavy_reg, rx_heavy_reg, led_out};

  // read mux uses next values so a read right after a write sees it
  wire  [15:0] rd_word =
      (addr_idx == slic_pkg::IDX_BEHAVIOUR) ? behaviour_next :
      (addr_idx == slic_pkg::IDX_COMMON)    ? common_next    :
      (addr_idx == slic_pkg::IDX_BLINK)     ? blink_next     :
      (addr_idx == slic_pkg::IDX_STATUS)    ? status_word    : 16'h0000;

  // bus phase tracking and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 16'h0000;
      hrdata_reg  <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= wr_take;
      wr_idx_reg  <= addr_idx;
      if (rd_take) begin
        hrdata_reg <= {16'h0000, rd_word};
      end
    end
  end

  // configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      behaviour_reg <= slic_pkg::RST_BEHAVIOUR;
      common_reg    <= slic_pkg::RST_COMMON;
      blink_reg     <= slic_pkg::RST_BLINK;
    end else begin
      behaviour_reg <= behaviour_next;
      common_reg    <= common_next;
      blink_reg     <= blink_next;
    end
  end

  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_reg;
  wire         ms_tick = (tick_cnt_reg == 32'(MS_TICKS - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= ms_tick ? 32'h0000_0000 : tick_cnt_reg + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // blink mode generators
  // ----------------------------------------------------------------
  // each mode runs off then on; the invert bit swaps the phases
  genvar m;
  generate
    for (m = 0; m < 4; m++) begin : g_mode
      logic [13:0] cnt_reg;
      wire  [3:0]  code =
          blink_reg[15 - 4*m -: slic_pkg::FREQ_W];
      wire  [27:0] ent  = freq_entry(code);
      wire  [13:0] per  = ent[27:14];
      wire  [13:0] off  = ent[13:0];
      wire         last = (cnt_reg >= per - 14'h1);
      wire         in_off = (cnt_reg < off);
      wire         inv  = common_reg[slic_pkg::C_INVERT];
      assign phase_on[m] = inv ? in_off : ~in_off;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_reg <= 14'h0000;
        end else if (ms_tick) begin
          cnt_reg <= last ? 14'h0000 : cnt_reg + 14'h1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // activity hold and traffic load
  // ----------------------------------------------------------------
  logic [3:0]  hold_reg;
  logic [9:0]  win_reg;
  logic [9:0]  tx_ms_reg;
  logic [9:0]  rx_ms_reg;

  wire link = phy_status.link_up;
  wire tx   = phy_status.tx_active;
  wire rx   = phy_status.rx_active;
  wire act_on_hit = link &
      ((tx & behaviour_reg[slic_pkg::B_TX_ON]) |
       (rx & behaviour_reg[slic_pkg::B_RX_ON]));
  wire win_end = ms_tick & (win_reg == 10'(slic_pkg::WINDOW_MS - 1));
  // 11 bits: the largest threshold, 31 x 42 ms, is beyond the window
  wire [10:0] th_ms = 11'(common_reg[slic_pkg::C_TH_HI:0]) *
                      11'(slic_pkg::TH_UNIT_MS);
  // totals include the millisecond that closes the window
  wire [10:0] tx_tot = {1'b0, tx_ms_reg} + {10'h000, tx};
  wire [10:0] rx_tot = {1'b0, rx_ms_reg} + {10'h000, rx};

  // hold the activity light for at least 10 ms after each event;
  // one spare tick, as the first tick may follow the event at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_reg <= 4'h0;
    end else if (act_on_hit) begin
      hold_reg <= 4'(slic_pkg::ACT_HOLD_MS + 1);
    end else if (ms_tick && hold_reg != 4'h0) begin
      hold_reg <= hold_reg - 4'h1;
    end
  end

  // 1 s window of active milliseconds, rx and tx apart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_reg      <= 10'h000;
      tx_ms_reg    <= 10'h000;
      rx_ms_reg    <= 10'h000;
      tx_heavy_reg <= 1'b0;
      rx_heavy_reg <= 1'b0;
    end else if (win_end) begin
      win_reg      <= 10'h000;
      tx_ms_reg    <= 10'h000;
      rx_ms_reg    <= 10'h000;
      tx_heavy_reg <= (tx_tot > th_ms);
      rx_heavy_reg <= (rx_tot > th_ms);
    end else if (ms_tick) begin
      win_reg   <= win_reg + 10'h1;
      tx_ms_reg <= tx_ms_reg + {9'h000, tx};
      rx_ms_reg <= rx_ms_reg + {9'h000, rx};
    end
  end

  // ----------------------------------------------------------------
  // indication selection
  // ----------------------------------------------------------------
  wire [15:0] b = behaviour_reg;
  wire [15:0] c = common_reg;

  // steady-on conditions
  wire dup_on  = link & ((b[slic_pkg::B_FDX_ON] & phy_status.full_duplex) |
                         (b[slic_pkg::B_HDX_ON] & ~phy_status.full_duplex));
  wire spd_on  = link & ((b[slic_pkg::B_FAST_ON] & phy_status.speed_fast) |
                         (b[slic_pkg::B_SLOW_ON] & ~phy_status.speed_fast));
  // the hold lights the led only while an activity-on enable is set
  wire act_on  = link & (hold_reg != 4'h0) &
                 (b[slic_pkg::B_TX_ON] | b[slic_pkg::B_RX_ON]);
  wire steady  = dup_on | spd_on | act_on;
  wire steady_en = b[slic_pkg::B_FDX_ON] | b[slic_pkg::B_HDX_ON] |
                   b[slic_pkg::B_FAST_ON] | b[slic_pkg::B_SLOW_ON] |
                   b[slic_pkg::B_TX_ON] | b[slic_pkg::B_RX_ON];

  // blink suppression in loopback and 10 Mb/s jabber
  wire lpbk_sup = phy_status.loopback & c[slic_pkg::C_LPBK_SUP];
  wire jab_sup  = phy_status.jabber & ~phy_status.speed_fast &
                  c[slic_pkg::C_JAB_SUP];
  wire suppress = lpbk_sup | jab_sup;

  // blink conditions
  wire col_blk = link & phy_status.collision &
                 b[slic_pkg::B_COL_BLK];
  wire fast_blk = b[slic_pkg::B_FAST_BLK] & phy_status.speed_fast;
  wire slow_blk = b[slic_pkg::B_SLOW_BLK] & ~phy_status.speed_fast;
  wire spd_blk  = link & (fast_blk | slow_blk);
  wire traffic = (tx & b[slic_pkg::B_TX_BLK]) | (rx & b[slic_pkg::B_RX_BLK]);
  wire act_gate = b[slic_pkg::B_FSEL_LO] | steady_en;
  wire act_cond = b[slic_pkg::B_ACT_ALW] | steady;
  wire act_blk = link & traffic & act_gate & act_cond;
  wire heavy   = (tx & tx_heavy_reg) | (rx & rx_heavy_reg);
  wire act_mode0 = c[slic_pkg::C_LVL_EN] & heavy;

  assign blink_active = ~suppress & (col_blk | spd_blk | act_blk);

  // forced, then collision, speed and activity blinks, then steady
  slic_pkg::slic_src_t src;
  always_comb begin
    src = slic_pkg::SLIC_SRC_OFF;
    if (b[slic_pkg::B_FORCE_EN]) begin
      unique case (b[slic_pkg::B_FSEL_HI:slic_pkg::B_FSEL_LO])
        slic_pkg::FORCE_BLK2: src = slic_pkg::SLIC_SRC_BLK2;
        slic_pkg::FORCE_BLK1: src = slic_pkg::SLIC_SRC_BLK1;
        slic_pkg::FORCE_ON:   src = slic_pkg::SLIC_SRC_ON;
        slic_pkg::FORCE_OFF:  src = slic_pkg::SLIC_SRC_OFF;
      endcase
    end else if (~suppress & col_blk) begin
      src = c[slic_pkg::C_COL_SEL] ? slic_pkg::SLIC_SRC_BLK2
                                   : slic_pkg::SLIC_SRC_BLK1;
    end else if (~suppress & spd_blk) begin
      src = slic_pkg::SLIC_SRC_BLK1;
    end else if (~suppress & act_blk) begin
      src = act_mode0 ? slic_pkg::SLIC_SRC_BLK0 : slic_pkg::SLIC_SRC_BLK2;
    end else if (steady) begin
      src = slic_pkg::SLIC_SRC_ON;
    end else if (phy_status.phy_active & phy_status.an_link_check &
                 b[slic_pkg::B_CHECK]) begin
      src = slic_pkg::SLIC_SRC_ON;
    end
  end

  // led level for the selected source
  logic led_next;
  always_comb begin
    led_next = 1'b0;
    unique case (src)
      slic_pkg::SLIC_SRC_OFF:  led_next = 1'b0;
      slic_pkg::SLIC_SRC_ON:   led_next = 1'b1;
      slic_pkg::SLIC_SRC_BLK0: led_next = phase_on[0];
      slic_pkg::SLIC_SRC_BLK1: led_next = phase_on[1];
      slic_pkg::SLIC_SRC_BLK2: led_next = phase_on[2];
      slic_pkg::SLIC_SRC_BLK3: led_next = phase_on[3];
    endcase
  end

  // registered led drive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_out <= 1'b0;
    end else begin
      led_out <= led_next;
    end
  end

endmodule
`default_nettype wire

// ===== bench/slic_assertions.sv
// concurrent checks on the ports of the status led block
`default_nettype none
module slic_assertions (
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       hsel,
  input wire logic [31:0]                haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic [31:0]                hwdata,
  input wire logic                       hready,
  input wire logic [31:0]                hrdata,
  input wire logic                       hreadyout,
  input wire logic                       hresp,
  input wire slic_pkg::slic_phy_status_t phy_status,
  input wire logic                       led_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        wp_reg;
  logic [15:0] wi_reg;
  logic [15:0] beh_reg;
  logic [15:0] blk_reg;
  logic [9:0]  cnt_reg;
  logic        lq_reg;
  // bus decode and status terms
  logic take, rdt, fen, lnk, lit, nob, fb;
  logic [1:0] fsel;
  assign take = hsel && htrans[1] && hready;
  assign rdt  = take && !hwrite;
  assign fen  = beh_reg[15];
  assign fsel = beh_reg[14:13];
  assign lnk  = phy_status.link_up;
  assign lit  = phy_status.phy_active && phy_status.an_link_check && beh_reg[0];
  assign nob  = beh_reg[9:8] == 2'h0 && beh_reg[3:1] == 3'h0;
  assign fb   = fen && fsel[1] && blk_reg == 16'heeee;
  // shadow copies of the behaviour and blink registers, stable run length while forced to blink with blink code eeee
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_reg  <= 1'b0;
      wi_reg  <= 16'h0;
      beh_reg <= slic_pkg::RST_BEHAVIOUR;
      blk_reg <= slic_pkg::RST_BLINK;
      cnt_reg <= 10'h0;
      lq_reg  <= 1'b0;
    end else begin
      wp_reg <= take && hwrite;
      wi_reg <= haddr[17:2];
      if (wp_reg && wi_reg == slic_pkg::IDX_BEHAVIOUR)
        beh_reg <= hwdata[15:0];
      if (wp_reg && wi_reg == slic_pkg::IDX_BLINK)
        blk_reg <= hwdata[15:0];
      cnt_reg <= (fb && led_out == lq_reg) ? cnt_reg + 10'h1 : 10'h0;
      lq_reg  <= led_out;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_force_on;
    fen && fsel == slic_pkg::FORCE_ON |=> led_out;
  endproperty
  a_force_on: assert property (p_force_on)
    else $error("forced on led dark");
  property p_force_off;
    fen && fsel == slic_pkg::FORCE_OFF |=> !led_out;
  endproperty
  a_force_off: assert property (p_force_off)
    else $error("forced off led lit");
  property p_check;
    !fen && !lnk && lit |=> led_out;
  endproperty
  a_check: assert property (p_check)
    else $error("link check light missing");
  property p_dark;
    !fen && !lnk && !lit |=> !led_out;
  endproperty
  a_dark: assert property (p_dark)
    else $error("led lit with link down");
  property p_fast_on;
    !fen && lnk && phy_status.speed_fast && beh_reg[5] && nob |=> led_out;
  endproperty
  a_fast_on: assert property (p_fast_on)
    else $error("fast speed led dark");
  property p_fdx_on;
    !fen && lnk && phy_status.full_duplex && beh_reg[11] && nob |=> led_out;
  endproperty
  a_fdx_on: assert property (p_fdx_on)
    else $error("full duplex led dark");
  property p_none;
    !fen && lnk && beh_reg[11:1] == 11'h0 && !lit |=> !led_out;
  endproperty
  a_none: assert property (p_none)
    else $error("led lit with nothing enabled");
  property p_blink;
    cnt_reg < 10'd700;
  endproperty
  a_blink: assert property (p_blink)
    else $error("forced blink stalled");
  property p_bus;
    rdt |=> hreadyout && !hresp && hrdata[31:16] == 16'h0;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bad read answer");
  c_blink: cover property (fb && $changed(led_out));
  c_check: cover property (!fen && !lnk && lit);
  c_fast: cover property (!fen && lnk && beh_reg[5] && nob);
endmodule
bind slic_top slic_assertions slic_assertions_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .phy_status(phy_status), .led_out(led_out));
`default_nettype wire

// ===== bench/slic_led_board.sv
// board led model: follows the drive level and counts its changes
`default_nettype none
module slic_led_board (
  input  wire logic hclk,
  input  wire logic led_out,
  output int        toggles
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  initial toggles = 0;
  // count every transition of the lamp
  always @(posedge hclk) begin
    if (led_out !== last)
      toggles <= toggles + 1;
    last <= led_out;
  end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the status led block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [2:0]  hsize = 3'h2;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        led_out;
  logic [31:0] rd;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  int          toggles;
  slic_pkg::slic_phy_status_t ps = '0;
  logic [15:0] pick [4] = '{slic_pkg::IDX_BEHAVIOUR, slic_pkg::IDX_COMMON,
                            slic_pkg::IDX_BLINK, 16'h40c7};
  logic [15:0] cc [5] = '{16'h0040, 16'h0000, 16'h0140, 16'h0040, 16'h00c0};
  logic [9:0]  cp [5] = '{10'h240, 10'h240, 10'h250, 10'h250, 10'h260};
  logic        ce [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  // clock, design and lamp
  always #5 hclk = ~hclk;
  slic_top #(.MS_TICKS(10)) slic_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .phy_status(ps), .led_out(led_out));
  slic_led_board slic_led_board_inst (
    .hclk(hclk), .led_out(led_out), .toggles(toggles));
  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 70000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] exp_reg(input logic [15:0] i,
                                          input logic [15:0] w);
    if (i == slic_pkg::IDX_COMMON)
      return w & slic_pkg::COMMON_MASK;
    if (i == slic_pkg::IDX_BLINK || i == slic_pkg::IDX_BEHAVIOUR)
      return w;
    return 16'h0;
  endfunction
  task automatic xfer(input logic w, input logic [15:0] i,
                      input logic [15:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {14'h0, i, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [15:0] i, input logic [15:0] d);
    xfer(1'b1, i, d);
  endtask
  task automatic rdchk(input logic [15:0] i, input logic [15:0] e);
    xfer(1'b0, i, 16'h0);
    chk(rd, {16'h0, e});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic lchk(input logic e);
    wt(3);
    @(negedge hclk);
    chk({31'h0, led_out}, {31'h0, e});
  endtask
  task automatic bchk(input logic e);
    int n0;
    n0 = toggles;
    wt(2000);
    chk({31'h0, toggles - n0 > 2}, {31'h0, e});
  endtask
  task automatic setps(input logic [9:0] v);
    ps <= v;
  endtask
  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    logic [15:0] i;
    logic [15:0] d;
    void'($urandom(32'h2223d9b6));
    wt(10);
    hresetn <= 1'b1;
    lchk(1'b0);
    rdchk(slic_pkg::IDX_BEHAVIOUR, slic_pkg::RST_BEHAVIOUR);
    rdchk(slic_pkg::IDX_COMMON, slic_pkg::RST_COMMON);
    rdchk(slic_pkg::IDX_BLINK, slic_pkg::RST_BLINK);
    for (int k = 0; k < 24; k++) begin
      i = pick[$urandom_range(3)];
      d = 16'($urandom);
      setps(10'($urandom));
      wr(i, d);
      rdchk(i, exp_reg(i, d));
    end
    setps(10'h0);
    wr(slic_pkg::IDX_BLINK, 16'heeee);
    for (int s = 0; s < 4; s++) begin
      wr(slic_pkg::IDX_BEHAVIOUR, 16'h8000 | 16'(s << 13));
      if (s < 2)
        lchk(s[0]);
      else
        bchk(1'b1);
    end
    setps(10'h00c);
    wr(slic_pkg::IDX_BEHAVIOUR, 16'h0001);
    lchk(1'b1);
    wr(slic_pkg::IDX_BEHAVIOUR, 16'h0000);
    lchk(1'b0);
    setps(10'h300);
    wr(slic_pkg::IDX_BEHAVIOUR, 16'h0020);
    lchk(1'b1);
    wr(slic_pkg::IDX_BEHAVIOUR, 16'h0800);
    lchk(1'b0);
    setps(10'h380);
    lchk(1'b1);
    wr(slic_pkg::IDX_BLINK, 16'he0ee);
    wr(slic_pkg::IDX_BEHAVIOUR, 16'h0008);
    for (int k = 0; k < 5; k++) begin
      setps(cp[k]);
      wr(slic_pkg::IDX_COMMON, cc[k]);
      bchk(ce[k]);
    end
    // collision at mode 2 outranks the fast speed blink at mode 1
    setps(10'h340);
    wr(slic_pkg::IDX_BEHAVIOUR, 16'h000c);
    bchk(1'b1);
    setps(10'h200);
    wr(slic_pkg::IDX_BEHAVIOUR, 16'h0080);
    setps(10'h202);
    wt(1);
    setps(10'h200);
    wt(75);
    lchk(1'b1);
    wt(36);
    lchk(1'b0);
    // speed blink, then activity blink with and without its gates
    wr(slic_pkg::IDX_BLINK, 16'heeee);
    setps(10'h300);
    wr(slic_pkg::IDX_BEHAVIOUR, 16'h0004);
    bchk(1'b1);
    setps(10'h302);
    wr(slic_pkg::IDX_BEHAVIOUR, 16'h0200);
    lchk(1'b0);
    wr(slic_pkg::IDX_BEHAVIOUR, 16'h0210);
    lchk(1'b0);
    wr(slic_pkg::IDX_BEHAVIOUR, 16'h1210);
    bchk(1'b1);
    wr(slic_pkg::IDX_COMMON, 16'h0001);
    setps(10'h202);
    wt(21000);
    xfer(1'b0, slic_pkg::IDX_STATUS, 16'h0);
    chk({30'h0, rd[2:1]}, 32'h2);
    // heavy tx: mode 0 (slow code) when level enabled, else fast blink
    wr(slic_pkg::IDX_BLINK, 16'h0ee0);
    wr(slic_pkg::IDX_BEHAVIOUR, 16'h0280);
    wr(slic_pkg::IDX_COMMON, 16'h0021);
    bchk(1'b0);
    wr(slic_pkg::IDX_COMMON, 16'h0001);
    bchk(1'b1);
    // mode 0 still sits in its short 600 ms off part; inversion turns it to on
    xfer(1'b0, slic_pkg::IDX_STATUS, 16'h0);
    chk({31'h0, rd[4]}, 32'h0);
    wr(slic_pkg::IDX_COMMON, 16'h0201);
    xfer(1'b0, slic_pkg::IDX_STATUS, 16'h0);
    chk({31'h0, rd[4]}, 32'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire
